// ---- inc/mc_pkg.sv ----
// package for the machine check error reporting block: register map, field layout, carriers
// assumes one clock domain; register ports follow the model-specific register and 32-bit mmio access styles
package mc_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int CORE_BANKS = 3;
  localparam int THREADS = 4;
  localparam int UNITS = 2;
  localparam int UNIT_W = 1;

  // ****************************************
  // model-specific register offsets
  // ****************************************
  localparam logic [31:0] GLOBAL_CAP_ADDR = 32'h0000_0179;
  localparam logic [31:0] GLOBAL_STATUS_ADDR = 32'h0000_017a;
  localparam logic [31:0] GLOBAL_CTL_ADDR = 32'h0000_017b;
  localparam logic [31:0] BANK_BASE = 32'h0000_0400;
  localparam logic [31:0] BANK_SPAN = 32'h0000_000c;
  localparam logic [1:0] REG_CTL = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_ADDR = 2'h2;
  localparam logic [1:0] REG_MISC = 2'h3;

  // uncore bank window: unit stride 32 bytes, eight 32-bit words per unit
  localparam logic [31:0] UNC_BASE = 32'h0000_9000;
  localparam logic [31:0] UNC_SPAN = 32'h0000_0040;
  localparam logic [2:0] UW_CTL_LO = 3'h0;
  localparam logic [2:0] UW_CTL_HI = 3'h1;
  localparam logic [2:0] UW_STATUS_LO = 3'h2;
  localparam logic [2:0] UW_STATUS_HI = 3'h3;
  localparam logic [2:0] UW_ADDR_LO = 3'h4;
  localparam logic [2:0] UW_ADDR_HI = 3'h5;
  localparam logic [2:0] UW_MISC = 3'h6;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int ST_VALID = 63;
  localparam int ST_OVER = 62;
  localparam int ST_UC = 61;
  localparam int ST_EN = 60;
  localparam int ST_MISCV = 59;
  localparam int ST_ADDRV = 58;
  localparam int ST_PCC = 57;
  localparam int GS_MCIP = 2;
  localparam logic [63:0] GLOBAL_CAP_VALUE = 64'h0000_0000_0000_0003;
  localparam logic [63:0] GLOBAL_CTL_RESET = 64'h0000_0000_0000_0000;
  localparam logic [63:0] ZERO64 = 64'h0;
  localparam logic [63:0] CTL_MASK [CORE_BANKS] = '{64'hffff_ffff_ffff_ffff, 64'h0000_0000_ffff_ffff,
                                                   64'hffff_ffff_ffff_ffff};
  localparam logic ADDR_IMPL [CORE_BANKS] = '{1'b0, 1'b1, 1'b1};
  localparam logic MISC_IMPL [CORE_BANKS] = '{1'b0, 1'b1, 1'b1};
  localparam logic [63:0] UNC_CTL_MASK = 64'h0000_0000_ffff_ffff;

  // serial frame toward the interrupt controller: start, unit, uncorrected
  localparam int FRAME_W = 2 + UNIT_W;
  localparam logic [1:0] FRAME_LAST = 2'(FRAME_W - 1);

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic valid;
    logic [1:0] bank;
    logic [5:0] enableIdx;
    logic [15:0] mcaCode;
    logic [15:0] modelCode;
    logic [24:0] info;
    logic uncorrected;
    logic contextCorrupt;
    logic addrValid;
    logic [63:0] addr;
  } errReport_t;

  typedef struct packed {
    logic req;
    logic write;
    logic [31:0] addr;
    logic [63:0] data;
    logic [1:0] thread;
  } regReq_t;

  typedef struct packed {
    logic ack;
    logic fault;
    logic [63:0] data;
  } regResp_t;

  typedef enum logic {LINK_IDLE, LINK_SEND} linkState_t;

  function automatic logic [63:0] status_entry(errReport_t e, logic miscOk);
    logic [63:0] s;
    s = ZERO64;
    s[15:0] = e.mcaCode;
    s[31:16] = e.modelCode;
    s[56:32] = e.info;
    s[ST_PCC] = e.contextCorrupt;
    s[ST_ADDRV] = e.addrValid;
    s[ST_MISCV] = miscOk & 1'b0;
    s[ST_EN] = 1'b1;
    s[ST_UC] = e.uncorrected;
    s[ST_VALID] = 1'b1;
    return s;
  endfunction

endpackage

// ---- rtl/machine_check_error_reporting.sv ----
// machine check detection and reporting: core banks, global registers, uncore banks and serial forwarding
// assumes error reports and register requests are synchronous to clk; one request per cycle per port
//
// Contract
// - machine checks work, yet the identification feature bits for them read clear
// - cache, memory crc and pci express link errors are detected and logged
// - core domain events raise machine checks; system domain events go via the uncore path
// - events are signalled without precise instruction synchronisation
// - one set of global machine check registers per cpu
// - three core banks, l1, l2 and tag directory, shared by all threads
// - each uncore unit has one bank of eight 32-bit registers
// - every uncore error whose enable flag is set is sent over a serial link to the interrupt controller
// - core machine check registers are shared, not duplicated per core
// - global capability, status and control are 64-bit; control is per thread
// - banks hold 64-bit control, status, address; 32-bit misc only in some; bank 0 implements no address register (access faults)
// - bank control holds 64 read/write enable flags; bank 1 and the uncore banks implement only the lower 32
// - writing all ones to bank control enables every supported error
// - writes to unimplemented control bits leave them unchanged
// - status valid sets only for a detected error whose enable flag is set
// - a new error while valid is set raises overflow; only software clears it
`timescale 1ns/1ps

module machine_check_error_reporting
  import mc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // error detectors
  input mc_pkg::errReport_t coreErr,
  input mc_pkg::errReport_t uncoreErr,
  // model-specific register access
  input mc_pkg::regReq_t msrReq,
  output mc_pkg::regResp_t msrResp,
  // uncore 32-bit mmio access
  input mc_pkg::regReq_t mmioReq,
  output mc_pkg::regResp_t mmioResp,
  // events
  output logic [mc_pkg::THREADS-1:0] mcExcept,
  output logic uncoreLinkTx,
  output logic [1:0] cpuidMcFeatures
);
  import mc_pkg::*;

  // ****************************************
  // core bank storage
  // ****************************************
  logic [63:0] bankCtl [CORE_BANKS];
  logic [63:0] bankStatus [CORE_BANKS];
  logic [63:0] bankAddr [CORE_BANKS];
  logic [31:0] bankMisc [CORE_BANKS];
  logic [63:0] globalStatus;
  logic [63:0] globalCtl [THREADS];

  logic [31:0] bankOff;
  logic inBanks;
  logic [1:0] bankSel;
  logic [1:0] regSel;
  logic msrWr;
  logic coreHit;
  logic coreEnabled;
  regResp_t next_msrResp;

  assign bankOff = msrReq.addr - BANK_BASE;
  assign inBanks = (msrReq.addr >= BANK_BASE) && (bankOff < BANK_SPAN);
  assign bankSel = bankOff[3:2];
  assign regSel = bankOff[1:0];
  assign msrWr = msrReq.req && msrReq.write;
  assign coreHit = coreErr.valid && (32'(coreErr.bank) < 32'(CORE_BANKS));
  assign coreEnabled = coreHit && bankCtl[coreErr.bank][coreErr.enableIdx];

  // ****************************************
  // core banks
  // ****************************************
  // one bank set serves every thread of the core, so there is no thread index here
  for (genvar i = 0; i < CORE_BANKS; i++) begin : g_bank
    logic selCtl;
    logic selStatus;
    logic selAddr;
    logic selMisc;
    logic logNow;
    logic clearNow;
    assign selCtl = msrWr && inBanks && bankSel == 2'(i) && regSel == REG_CTL;
    assign selStatus = msrWr && inBanks && bankSel == 2'(i) && regSel == REG_STATUS;
    assign selAddr = msrWr && inBanks && bankSel == 2'(i) && regSel == REG_ADDR;
    assign selMisc = msrWr && inBanks && bankSel == 2'(i) && regSel == REG_MISC;
    assign logNow = coreEnabled && coreErr.bank == 2'(i);
    // only an all-zero write clears; other values fault and store nothing
    assign clearNow = selStatus && msrReq.data == ZERO64;

    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        bankCtl[i] <= ZERO64;
      end else if (selCtl) begin
        bankCtl[i] <= (bankCtl[i] & ~CTL_MASK[i]) | (msrReq.data & CTL_MASK[i]);
      end
    end

    // a fresh error wins over a clear in the same cycle; the clear empties the entry first
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        bankStatus[i] <= ZERO64;
      end else if (logNow) begin
        if (bankStatus[i][ST_VALID] && !clearNow) begin
          bankStatus[i][ST_OVER] <= 1'b1;
        end else begin
          bankStatus[i] <= status_entry(coreErr, MISC_IMPL[i]);
        end
      end else if (clearNow) begin
        bankStatus[i] <= ZERO64;
      end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        bankAddr[i] <= ZERO64;
      end else if (ADDR_IMPL[i] && logNow && coreErr.addrValid && (!bankStatus[i][ST_VALID] || clearNow)) begin
        bankAddr[i] <= coreErr.addr;
      end else if (ADDR_IMPL[i] && selAddr) begin
        bankAddr[i] <= msrReq.data;
      end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        bankMisc[i] <= 32'h0;
      end else if (MISC_IMPL[i] && selMisc) begin
        bankMisc[i] <= msrReq.data[31:0];
      end
    end
  end

  // ****************************************
  // global registers
  // ****************************************
  for (genvar t = 0; t < THREADS; t++) begin : g_thread
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        globalCtl[t] <= GLOBAL_CTL_RESET;
      end else if (msrWr && msrReq.addr == GLOBAL_CTL_ADDR && msrReq.thread == 2'(t)) begin
        globalCtl[t] <= msrReq.data;
      end
    end

    // raised from the logging event, not from the retiring instruction
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        mcExcept[t] <= 1'b0;
      end else begin
        mcExcept[t] <= coreEnabled && globalCtl[t][coreErr.bank];
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      globalStatus <= ZERO64;
    end else if (msrWr && msrReq.addr == GLOBAL_STATUS_ADDR) begin
      globalStatus <= msrReq.data | {61'h0, coreEnabled, 2'h0};
    end else if (coreEnabled) begin
      globalStatus[GS_MCIP] <= 1'b1;
    end
  end

  // feature bits stay clear even though the machinery is present
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cpuidMcFeatures <= 2'h0;
    end else begin
      cpuidMcFeatures <= 2'h0;
    end
  end

  // ****************************************
  // msr read and answer
  // ****************************************
  always_comb begin
    next_msrResp = '0;
    next_msrResp.ack = msrReq.req;
    if (msrReq.addr == GLOBAL_CAP_ADDR) begin
      next_msrResp.data = GLOBAL_CAP_VALUE;
      next_msrResp.fault = msrReq.write;
    end else if (msrReq.addr == GLOBAL_STATUS_ADDR) begin
      next_msrResp.data = globalStatus;
    end else if (msrReq.addr == GLOBAL_CTL_ADDR) begin
      next_msrResp.data = globalCtl[msrReq.thread];
    end else if (inBanks) begin
      unique case (regSel)
        REG_CTL: next_msrResp.data = bankCtl[bankSel];
        REG_STATUS: begin
          next_msrResp.data = bankStatus[bankSel];
          next_msrResp.fault = msrReq.write && msrReq.data != ZERO64;
        end
        REG_ADDR: begin
          next_msrResp.data = bankAddr[bankSel];
          next_msrResp.fault = !ADDR_IMPL[bankSel];
        end
        REG_MISC: begin
          next_msrResp.data = {32'h0, bankMisc[bankSel]};
          next_msrResp.fault = !MISC_IMPL[bankSel];
        end
      endcase
    end else begin
      next_msrResp.fault = 1'b1;
    end
    if (!msrReq.req) begin
      next_msrResp = '0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      msrResp <= '0;
    end else begin
      msrResp <= next_msrResp;
    end
  end

  // ****************************************
  // uncore banks
  // ****************************************
  logic [63:0] uncCtl [UNITS];
  logic [63:0] uncStatus [UNITS];
  logic [63:0] uncAddr [UNITS];
  logic [31:0] uncMisc [UNITS];
  logic [UNITS-1:0] pending;
  logic [UNITS-1:0] pendingUc;
  logic [UNITS-1:0] launch;
  logic [31:0] uncOff;
  logic inUnc;
  logic [UNIT_W-1:0] unitSel;
  logic [2:0] wordSel;
  logic mmioWr;
  logic uncHit;
  logic uncEnabled;
  regResp_t next_mmioResp;

  assign uncOff = mmioReq.addr - UNC_BASE;
  assign inUnc = (mmioReq.addr >= UNC_BASE) && (uncOff < UNC_SPAN) && uncOff[1:0] == 2'h0;
  assign unitSel = uncOff[5 +: UNIT_W];
  assign wordSel = uncOff[4:2];
  assign mmioWr = mmioReq.req && mmioReq.write && inUnc;
  assign uncHit = uncoreErr.valid && (32'(uncoreErr.bank) < 32'(UNITS));
  assign uncEnabled = uncHit && uncCtl[uncoreErr.bank[UNIT_W-1:0]][uncoreErr.enableIdx];

  for (genvar u = 0; u < UNITS; u++) begin : g_unit
    logic sel;
    logic logNow;
    logic clrLo;
    logic clrHi;
    assign sel = mmioWr && unitSel == UNIT_W'(u);
    assign logNow = uncEnabled && uncoreErr.bank[UNIT_W-1:0] == UNIT_W'(u);
    assign clrLo = sel && wordSel == UW_STATUS_LO && mmioReq.data[31:0] == 32'h0;
    assign clrHi = sel && wordSel == UW_STATUS_HI && mmioReq.data[31:0] == 32'h0;

    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        uncCtl[u] <= ZERO64;
      end else if (sel && wordSel == UW_CTL_LO) begin
        uncCtl[u][31:0] <= (uncCtl[u][31:0] & ~UNC_CTL_MASK[31:0]) | (mmioReq.data[31:0] & UNC_CTL_MASK[31:0]);
      end else if (sel && wordSel == UW_CTL_HI) begin
        uncCtl[u][63:32] <= (uncCtl[u][63:32] & ~UNC_CTL_MASK[63:32]) | (mmioReq.data[31:0] & UNC_CTL_MASK[63:32]);
      end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        uncStatus[u] <= ZERO64;
      end else if (logNow) begin
        if (uncStatus[u][ST_VALID] && !clrHi) begin
          uncStatus[u][ST_OVER] <= 1'b1;
        end else begin
          uncStatus[u] <= status_entry(uncoreErr, 1'b1);
        end
      end else if (clrLo) begin
        uncStatus[u][31:0] <= 32'h0;
      end else if (clrHi) begin
        uncStatus[u][63:32] <= 32'h0;
      end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        uncAddr[u] <= ZERO64;
      // a clear of the upper status word in the same cycle makes room for the new address
      end else if (logNow && uncoreErr.addrValid && (!uncStatus[u][ST_VALID] || clrHi)) begin
        uncAddr[u] <= uncoreErr.addr;
      end else if (sel && wordSel == UW_ADDR_LO) begin
        uncAddr[u][31:0] <= mmioReq.data[31:0];
      end else if (sel && wordSel == UW_ADDR_HI) begin
        uncAddr[u][63:32] <= mmioReq.data[31:0];
      end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        uncMisc[u] <= 32'h0;
      end else if (sel && wordSel == UW_MISC) begin
        uncMisc[u] <= mmioReq.data[31:0];
      end
    end

    // an event landing while its frame is launched stays pending for the next frame
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        pending[u] <= 1'b0;
        pendingUc[u] <= 1'b0;
      end else if (logNow) begin
        pending[u] <= 1'b1;
        pendingUc[u] <= uncoreErr.uncorrected | (pendingUc[u] & ~launch[u]);
      end else if (launch[u]) begin
        pending[u] <= 1'b0;
        pendingUc[u] <= 1'b0;
      end
    end
  end

  always_comb begin
    next_mmioResp = '0;
    next_mmioResp.ack = mmioReq.req;
    next_mmioResp.fault = mmioReq.req && !inUnc;
    if (inUnc) begin
      unique case (wordSel)
        UW_CTL_LO: next_mmioResp.data[31:0] = uncCtl[unitSel][31:0];
        UW_CTL_HI: next_mmioResp.data[31:0] = uncCtl[unitSel][63:32];
        UW_STATUS_LO: next_mmioResp.data[31:0] = uncStatus[unitSel][31:0];
        UW_STATUS_HI: next_mmioResp.data[31:0] = uncStatus[unitSel][63:32];
        UW_ADDR_LO: next_mmioResp.data[31:0] = uncAddr[unitSel][31:0];
        UW_ADDR_HI: next_mmioResp.data[31:0] = uncAddr[unitSel][63:32];
        UW_MISC: next_mmioResp.data[31:0] = uncMisc[unitSel];
        default: next_mmioResp.data = ZERO64;
      endcase
      if (mmioReq.write && (wordSel == UW_STATUS_LO || wordSel == UW_STATUS_HI)) begin
        next_mmioResp.fault = mmioReq.data[31:0] != 32'h0;
      end
    end
    if (!mmioReq.req) begin
      next_mmioResp = '0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mmioResp <= '0;
    end else begin
      mmioResp <= next_mmioResp;
    end
  end

  // ****************************************
  // serial link to the interrupt controller
  // ****************************************
  // lowest unit number goes first; a busy link delays an event, and further events of a still pending unit merge into its one frame
  linkState_t linkState;
  logic [FRAME_W-1:0] frame;
  logic [1:0] bitCount;
  logic [UNIT_W-1:0] pick;
  logic anyPending;

  always_comb begin
    pick = '0;
    anyPending = 1'b0;
    for (int k = UNITS - 1; k >= 0; k--) begin
      if (pending[k]) begin
        pick = UNIT_W'(k);
        anyPending = 1'b1;
      end
    end
  end

  for (genvar u = 0; u < UNITS; u++) begin : g_launch
    assign launch[u] = linkState == LINK_IDLE && anyPending && pick == UNIT_W'(u);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      linkState <= LINK_IDLE;
      frame <= '0;
      bitCount <= 2'h0;
      uncoreLinkTx <= 1'b0;
    end else begin
      unique case (linkState)
        LINK_IDLE: begin
          uncoreLinkTx <= 1'b0;
          if (anyPending) begin
            frame <= {pendingUc[pick], pick, 1'b1};
            bitCount <= 2'h0;
            linkState <= LINK_SEND;
          end
        end
        LINK_SEND: begin
          uncoreLinkTx <= frame[0];
          frame <= frame >> 1;
          bitCount <= bitCount + 2'h1;
          if (bitCount == FRAME_LAST) begin
            linkState <= LINK_IDLE;
          end
        end
      endcase
    end
  end

endmodule

// ---- test/machine_check_monitor.sv ----
// checker for the machine check error reporting block: port-level timing and value relations
// assumes it is bound to the top module and sees only its ports, one clock domain
`timescale 1ns/1ps

module machine_check_monitor
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // error detectors
  input mc_pkg::errReport_t coreErr,
  input mc_pkg::errReport_t uncoreErr,
  // register ports
  input mc_pkg::regReq_t msrReq,
  input mc_pkg::regResp_t msrResp,
  input mc_pkg::regReq_t mmioReq,
  input mc_pkg::regResp_t mmioResp,
  // events
  input wire logic [mc_pkg::THREADS-1:0] mcExcept,
  input wire logic uncoreLinkTx,
  input wire logic [1:0] cpuidMcFeatures
);
  import mc_pkg::*;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_FEATURE_CLEAR: assert property (cpuidMcFeatures == 2'h0)
    else $error("feature bits not clear");
  AST_MSR_ANSWER: assert property (msrReq.req |=> msrResp.ack)
    else $error("msr request without answer");
  AST_MSR_NO_STRAY: assert property (msrResp.ack |-> $past(msrReq.req))
    else $error("msr answer without request");
  AST_MMIO_ANSWER: assert property (mmioReq.req |=> mmioResp.ack && mmioResp.data[63:32] == 32'h0)
    else $error("mmio answer missing or wider than 32 bits");
  AST_MMIO_FAULT_ACK: assert property (mmioResp.fault |-> mmioResp.ack)
    else $error("mmio fault outside an answer");
  AST_CAP_VALUE: assert property (msrReq.req && !msrReq.write && msrReq.addr == GLOBAL_CAP_ADDR
    |=> msrResp.data == GLOBAL_CAP_VALUE && !msrResp.fault) else $error("capability read wrong");
  AST_CTL_ACCEPTED: assert property (msrReq.req && msrReq.addr inside {32'h400, 32'h404, 32'h408}
    |=> msrResp.ack && !msrResp.fault) else $error("bank control access refused");
  AST_STATUS_ONES_REFUSED: assert property (msrReq.req && msrReq.write && msrReq.addr == 32'h405
    && msrReq.data != ZERO64 |=> msrResp.fault) else $error("nonzero status write accepted");
  AST_EXCEPT_CAUSE: assert property (|mcExcept |-> $past(coreErr.valid))
    else $error("machine check without error report");
  AST_LINK_FRAME_LEN: assert property (uncoreLinkTx [*3] |=> !uncoreLinkTx)
    else $error("link frame too long");
endmodule

bind machine_check_error_reporting machine_check_monitor i_machine_check_monitor (.clk(clk), .sys_rst(sys_rst),
  .coreErr(coreErr), .uncoreErr(uncoreErr), .msrReq(msrReq), .msrResp(msrResp), .mmioReq(mmioReq),
  .mmioResp(mmioResp), .mcExcept(mcExcept), .uncoreLinkTx(uncoreLinkTx), .cpuidMcFeatures(cpuidMcFeatures));

// ---- test/testbench.sv ----
// self-checking bench for the machine check error reporting block
// assumes the package mc_pkg is compiled first; inputs change 1 ns after the rising edge
`timescale 1ns/1ps

module testbench;
  import mc_pkg::*;

  // ****************************************
  // signals and design
  // ****************************************
  logic clk;
  logic sys_rst;
  errReport_t coreErr;
  errReport_t uncoreErr;
  regReq_t msrReq;
  regReq_t mmioReq;
  regResp_t msrResp;
  regResp_t mmioResp;
  logic [THREADS-1:0] mcExcept;
  logic uncoreLinkTx;
  logic [1:0] cpuidMcFeatures;
  int nMismatch = 0;
  int checksDone = 0;

  machine_check_error_reporting i_machine_check_error_reporting (.clk(clk), .sys_rst(sys_rst),
    .coreErr(coreErr), .uncoreErr(uncoreErr), .msrReq(msrReq), .msrResp(msrResp), .mmioReq(mmioReq),
    .mmioResp(mmioResp), .mcExcept(mcExcept), .uncoreLinkTx(uncoreLinkTx), .cpuidMcFeatures(cpuidMcFeatures));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk64(input logic [63:0] got, input logic [63:0] exp, input string msg);
    checksDone++;
    if (got !== exp) begin
      nMismatch++;
      $display("unexpected at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // one request, held for one edge; the answer is taken 1 ns after that same edge
  task automatic xfer(input logic mm, input logic w, input logic [31:0] a, input logic [63:0] d,
                      input logic [1:0] t, input logic [63:0] e, input logic [63:0] m, input logic f);
    regResp_t r;
    @(posedge clk) #1;
    if (mm) mmioReq = '{1'b1, w, a, d, t};
    else msrReq = '{1'b1, w, a, d, t};
    @(posedge clk) #1;
    msrReq.req = 1'b0;
    mmioReq.req = 1'b0;
    r = mm ? mmioResp : msrResp;
    chk64({62'h0, r.ack, r.fault}, {62'h0, 1'b1, f}, "ack and fault");
    if (!w && !f) chk64(r.data & m, e, "read data");
  endtask

  task automatic inject(input logic unc, input logic [1:0] b, input logic [5:0] j, output logic [3:0] ex);
    errReport_t e;
    e = '{1'b1, b, j, 16'h1234, 16'h00a5, 25'h0, 1'b1, 1'b0, 1'b1, 64'h0000_0000_0000_1000};
    @(posedge clk) #1;
    if (unc) uncoreErr = e;
    else coreErr = e;
    @(posedge clk) #1;
    coreErr.valid = 1'b0;
    uncoreErr.valid = 1'b0;
    ex = mcExcept;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_idle();
    chk64({62'h0, cpuidMcFeatures}, 64'h0, "feature bits");
    xfer(0, 0, GLOBAL_CAP_ADDR, 64'h0, 2'h0, GLOBAL_CAP_VALUE, '1, 0);
    xfer(0, 0, 32'h400, 64'h0, 2'h0, 64'h0, '1, 0);
    xfer(0, 0, 32'h500, 64'h0, 2'h0, 64'h0, '1, 1);
    xfer(0, 0, 32'h402, 64'h0, 2'h0, 64'h0, '1, 1);
  endtask

  task automatic t_control();
    for (int i = 0; i < CORE_BANKS; i++) begin
      xfer(0, 1, 32'h400 + 32'(4 * i), '1, 2'h0, 64'h0, '1, 0);
      xfer(0, 0, 32'h400 + 32'(4 * i), 64'h0, 2'h0, CTL_MASK[i], '1, 0);
    end
    // back to back: clear, then try the unimplemented upper half
    xfer(0, 1, 32'h404, 64'h0, 2'h0, 64'h0, '1, 0);
    xfer(0, 1, 32'h404, 64'hffff_ffff_0000_0000, 2'h0, 64'h0, '1, 0);
    xfer(0, 0, 32'h404, 64'h0, 2'h0, 64'h0, '1, 0);
    xfer(0, 1, 32'h404, 64'h0000_0000_0000_0008, 2'h0, 64'h0, '1, 0);
    xfer(0, 1, GLOBAL_CTL_ADDR, 64'h2, 2'h1, 64'h0, '1, 0);
    xfer(0, 0, GLOBAL_CTL_ADDR, 64'h0, 2'h0, 64'h0, '1, 0);
    xfer(0, 0, GLOBAL_CTL_ADDR, 64'h0, 2'h1, 64'h2, '1, 0);
  endtask

  task automatic t_core_error();
    logic [3:0] ex;
    inject(0, 2'h1, 6'd40, ex);
    chk64({60'h0, ex}, 64'h0, "disabled error raised event");
    xfer(0, 0, 32'h405, 64'h0, 2'h0, 64'h0, '1, 0);
    inject(0, 2'h1, 6'd3, ex);
    chk64({60'h0, ex}, 64'h2, "event threads");
    xfer(0, 0, 32'h405, 64'h0, 2'h0, 64'hb400_0000_00a5_1234, '1, 0);
    xfer(0, 0, 32'h406, 64'h0, 2'h0, 64'h1000, '1, 0);
    xfer(0, 0, GLOBAL_STATUS_ADDR, 64'h0, 2'h0, 64'h4, 64'h4, 0);
    inject(0, 2'h1, 6'd3, ex);
    xfer(0, 0, 32'h405, 64'h0, 2'h0, 64'hf400_0000_00a5_1234, '1, 0);
    xfer(0, 1, 32'h405, '1, 2'h0, 64'h0, '1, 1);
    xfer(0, 0, 32'h405, 64'h0, 2'h0, 64'hf400_0000_00a5_1234, '1, 0);
    xfer(0, 1, 32'h405, 64'h0, 2'h0, 64'h0, '1, 0);
    xfer(0, 0, 32'h405, 64'h0, 2'h0, 64'h0, '1, 0);
  endtask

  task automatic t_uncore();
    logic [3:0] ex;
    logic [3:0] frame;
    // unit 0 left disabled: the line must stay idle
    inject(1, 2'h0, 6'd0, ex);
    repeat (8) begin
      @(posedge clk) #1;
      chk64({63'h0, uncoreLinkTx}, 64'h0, "frame for disabled unit");
    end
    xfer(1, 1, UNC_BASE + 32'h20, 64'hffff_ffff, 2'h0, 64'h0, '1, 0);
    xfer(1, 0, UNC_BASE + 32'h24, 64'h0, 2'h0, 64'h0, '1, 0);
    xfer(1, 0, UNC_BASE + 32'h22, 64'h0, 2'h0, 64'h0, '1, 1);
    inject(1, 2'h1, 6'd0, ex);
    frame = 4'b1110;
    repeat (2) @(posedge clk);
    for (int i = 3; i >= 0; i--) begin
      #1;
      chk64({63'h0, uncoreLinkTx}, {63'h0, frame[i]}, "link bit");
      @(posedge clk);
    end
    xfer(1, 0, UNC_BASE + 32'h28, 64'h0, 2'h0, 64'h00a5_1234, '1, 0);
    xfer(1, 0, UNC_BASE + 32'h2c, 64'h0, 2'h0, 64'hb000_0000, 64'hf000_0000, 0);
  endtask

  // ****************************************
  // run control
  // ****************************************
  task automatic stopTest();
    $display("comparisons %0d mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    sys_rst = 1'b1;
    coreErr = '0;
    uncoreErr = '0;
    msrReq = '0;
    mmioReq = '0;
    repeat (20) @(posedge clk);
    #1 sys_rst = 1'b0;
    t_idle();
    t_control();
    t_core_error();
    t_uncore();
    stopTest();
  end

  // the whole run needs well under 300 cycles; this allows a wide margin
  initial begin
    #100us;
    nMismatch++;
    stopTest();
  end
endmodule
